// ### logic/dpsr_map.vh
// shared constants for the dual-port ddr sram interface
// included by the design file; holds definitions only
`ifndef DPSR_MAP_VH
`define DPSR_MAP_VH
`define DPSR_LANE_W 9
`define DPSR_DW_NARROW 18
`define DPSR_AW_NARROW 19
`define DPSR_DW_WIDE 36
`define DPSR_AW_WIDE 18
`define DPSR_FIFO_DEPTH 8
`define DPSR_SINGLE_DET 2
`define DPSR_Q_RESET 18'h00000
`endif

// ### logic/dpsr_top.v
// dual-port ddr sram core with write fifo, pin level ports
// assumes strobes and inputs arrive as pins, sampled on clk (20 MHz)
// Operation
// - only lanes with active mask bit are written
// - mask bit n governs data lane n
// - mask captured on same edge as data
// - read address on true, write on complementary
// - address 19 bits narrow, 18 bits wide
// - address ignored when its port unselected
// - read data launched on both output strobes, or both input strobes in single-clock mode
// - read select sampled on true strobe starts read
// - deselect: finish burst, then tristate outputs
// - each read gives two sequential beats
// - every access starts on true input strobe
// - second beat captured on complementary strobe
// - free-running returned strobe follows output strobes, or input strobes in single-clock mode
// - write select sampled on true strobe starts write
// - write data captured one beat per edge
`timescale 1ns/1ps
`include "dpsr_map.vh"
`default_nettype none

module dpsr_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = `DPSR_FIFO_DEPTH,
   parameter PW = 3
)(
   input wire clk,
   input wire resetn,
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [PW-1:0] wp_r;
   reg [PW-1:0] rp_r;
   reg [PW:0] cnt_r;
   wire push;
   wire pop;
   assign in_ready = (cnt_r != DEPTH[PW:0]);
   assign out_valid = (cnt_r != {(PW+1){1'b0}});
   assign out_data = mem[rp_r];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   always @(posedge clk)
   begin
      if (push)
         mem[wp_r] <= in_data;
   end
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         wp_r <= {PW{1'b0}};
         rp_r <= {PW{1'b0}};
         cnt_r <= {(PW+1){1'b0}};
      end
      else
      begin
         if (push)
            wp_r <= (wp_r == DEPTH[PW-1:0] - 1'b1) ? {PW{1'b0}} : wp_r + 1'b1;
         if (pop)
            rp_r <= (rp_r == DEPTH[PW-1:0] - 1'b1) ? {PW{1'b0}} : rp_r + 1'b1;
         if (push & ~pop)
            cnt_r <= cnt_r + 1'b1;
         else if (pop & ~push)
            cnt_r <= cnt_r - 1'b1;
      end
   end
endmodule // dpsr_fifo

module dpsr_top #(
   parameter DW = `DPSR_DW_NARROW,
   parameter AW = `DPSR_AW_NARROW,
   parameter LANES = DW / `DPSR_LANE_W
)(
   input wire clk,
   input wire resetn,
   input wire k_in,
   input wire k_n_in,
   input wire c_in,
   input wire c_n_in,
   input wire [AW-1:0] addr,
   input wire [DW-1:0] write_bus_in,
   input wire [LANES-1:0] byte_lane_mask_n,
   input wire read_port_sel_n,
   input wire write_port_sel_n,
   output reg [DW-1:0] read_bus_out,
   output reg read_bus_oe_n,
   output reg returned_strobe,
   output reg returned_strobe_n,
   output wire write_ready
);
   localparam LW = `DPSR_LANE_W;
   localparam IW = 4 + AW + DW + LANES;
   localparam FW = AW + 2 * (DW + LANES);
   localparam S_IDLE = 3'b001;
   localparam S_BEAT0 = 3'b010;
   localparam S_BEAT1 = 3'b100;
   // two-flop sampling of every pin
   reg [IW-1:0] meta_r;
   reg [IW-1:0] sync_r;
   reg [3:0] clk_prev_r;
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         meta_r <= {IW{1'b0}};
         sync_r <= {IW{1'b0}};
         clk_prev_r <= 4'h0;
      end
      else
      begin
         meta_r <= {k_in, k_n_in, c_in, c_n_in, addr, write_bus_in,
            byte_lane_mask_n};
         sync_r <= meta_r;
         clk_prev_r <= sync_r[IW-1:IW-4];
      end
   end
   wire k_s = sync_r[IW-1];
   wire kn_s = sync_r[IW-2];
   wire c_s = sync_r[IW-3];
   wire cn_s = sync_r[IW-4];
   wire [AW-1:0] a_s = sync_r[AW+DW+LANES-1:DW+LANES];
   wire [DW-1:0] d_s = sync_r[DW+LANES-1:LANES];
   wire [LANES-1:0] m_s = sync_r[LANES-1:0];
   reg [1:0] sel_meta_r;
   reg [1:0] sel_r;
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sel_meta_r <= 2'h3;
         sel_r <= 2'h3;
      end
      else
      begin
         sel_meta_r <= {read_port_sel_n, write_port_sel_n};
         sel_r <= sel_meta_r;
      end
   end
   wire k_rise = k_s & ~clk_prev_r[3];
   wire kn_rise = kn_s & ~clk_prev_r[2];
   wire c_rise = c_s & ~clk_prev_r[1];
   wire cn_rise = cn_s & ~clk_prev_r[0];
   // single-clock mode when both output strobes sit high
   reg [1:0] hi_cnt_r;
   reg single_r;
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         hi_cnt_r <= 2'h0;
         single_r <= 1'b0;
      end
      else if (c_s & cn_s)
      begin
         if (hi_cnt_r != `DPSR_SINGLE_DET)
            hi_cnt_r <= hi_cnt_r + 2'h1;
         else
            single_r <= 1'b1;
      end
      else
      begin
         hi_cnt_r <= 2'h0;
         single_r <= 1'b0;
      end
   end
   wire ot_rise = single_r ? k_rise : c_rise;
   wire otn_rise = single_r ? kn_rise : cn_rise;
   // returned strobe pair
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         returned_strobe <= 1'b0;
         returned_strobe_n <= 1'b1;
      end
      else
      begin
         returned_strobe <= single_r ? k_s : c_s;
         returned_strobe_n <= single_r ? kn_s : cn_s;
      end
   end
   // each address holds a pair of words
   reg [DW-1:0] mem [0:(2 << AW)-1];
   // write capture
   reg wr_pend_r;
   reg [DW-1:0] wd0_r;
   reg [LANES-1:0] wm0_r;
   reg push_r;
   reg [FW-1:0] push_data_r;
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         wr_pend_r <= 1'b0;
         wd0_r <= {DW{1'b0}};
         wm0_r <= {LANES{1'b1}};
         push_r <= 1'b0;
         push_data_r <= {FW{1'b0}};
      end
      else
      begin
         push_r <= 1'b0;
         if (k_rise)
         begin
            wr_pend_r <= ~sel_r[0] & write_ready;
            wd0_r <= d_s;
            wm0_r <= m_s;
         end
         else if (kn_rise && wr_pend_r)
         begin
            wr_pend_r <= 1'b0;
            push_r <= 1'b1;
            push_data_r <= {a_s, wd0_r, wm0_r, d_s, m_s};
         end
      end
   end
   // read fetch
   reg rd_req_r;
   reg [AW-1:0] ra_r;
   reg [DW-1:0] rd0_r;
   reg [DW-1:0] rd1_r;
   reg rd_pend_r;
   wire rd_fetch = rd_req_r;
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rd_req_r <= 1'b0;
         ra_r <= {AW{1'b0}};
      end
      else
      begin
         rd_req_r <= k_rise & ~sel_r[1];
         if (k_rise && !sel_r[1])
            ra_r <= a_s;
      end
   end
   // write drain, stalled while a read uses the array
   wire f_valid;
   wire [FW-1:0] f_data;
   wire f_ready = ~rd_fetch;
   dpsr_fifo #(.WIDTH(FW), .DEPTH(`DPSR_FIFO_DEPTH), .PW(3)) u_fifo (
      .clk(clk),
      .resetn(resetn),
      .in_valid(push_r),
      .in_ready(write_ready),
      .in_data(push_data_r),
      .out_valid(f_valid),
      .out_ready(f_ready),
      .out_data(f_data)
   );
   wire [AW-1:0] fa = f_data[FW-1:FW-AW];
   wire [DW-1:0] fd0 = f_data[FW-AW-1:FW-AW-DW];
   wire [LANES-1:0] fm0 = f_data[DW+2*LANES-1:DW+LANES];
   wire [DW-1:0] fd1 = f_data[DW+LANES-1:LANES];
   wire [LANES-1:0] fm1 = f_data[LANES-1:0];
   wire [DW-1:0] new0;
   wire [DW-1:0] new1;
   genvar g;
   generate
      for (g = 0; g < LANES; g = g + 1)
      begin : g_lane
         assign new0[g*LW +: LW] = fm0[g] ? mem[{fa, 1'b0}][g*LW +: LW] :
            fd0[g*LW +: LW];
         assign new1[g*LW +: LW] = fm1[g] ? mem[{fa, 1'b1}][g*LW +: LW] :
            fd1[g*LW +: LW];
      end
   endgenerate
   // read output sequencer
   reg [2:0] st_r;
   always @(posedge clk)
   begin
      if (rd_fetch)
      begin
         rd0_r <= mem[{ra_r, 1'b0}];
         rd1_r <= mem[{ra_r, 1'b1}];
      end
      else if (f_valid)
      begin
         mem[{fa, 1'b0}] <= new0;
         mem[{fa, 1'b1}] <= new1;
      end
   end
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         st_r <= S_IDLE;
         rd_pend_r <= 1'b0;
         read_bus_out <= {DW{1'b0}};
         read_bus_oe_n <= 1'b1;
      end
      else
      begin
         if (rd_fetch)
            rd_pend_r <= 1'b1;
         case (st_r)
            S_IDLE, S_BEAT1:
            begin
               if (ot_rise)
               begin
                  if (rd_pend_r && !rd_fetch)
                  begin
                     read_bus_out <= rd0_r;
                     read_bus_oe_n <= 1'b0;
                     rd_pend_r <= 1'b0;
                     st_r <= S_BEAT0;
                  end
                  else
                  begin
                     read_bus_oe_n <= 1'b1;
                     st_r <= S_IDLE;
                  end
               end
            end
            S_BEAT0:
            begin
               if (otn_rise)
               begin
                  read_bus_out <= rd1_r;
                  st_r <= S_BEAT1;
               end
            end
            default:
               st_r <= S_IDLE;
         endcase
      end
   end
endmodule // dpsr_top
`default_nettype wire

// ### verification/dpsr_top_asserts.sv
// pin checker for dpsr_top, read side and strobes
// bound into every dpsr_top instance
`timescale 1ns/1ps
`default_nettype none
module dpsr_top_asserts #(
   parameter DW = 18
)(
   input wire logic clk,
   input wire logic resetn,
   input wire logic c_in,
   input wire logic c_n_in,
   input wire logic read_port_sel_n,
   input wire logic [DW-1:0] read_bus_out,
   input wire logic read_bus_oe_n,
   input wire logic returned_strobe,
   input wire logic returned_strobe_n,
   input wire logic write_ready
);
   logic [5:0] idle_r;
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         idle_r <= 6'h00;
      else if (!read_port_sel_n)
         idle_r <= 6'h00;
      else if (idle_r != 6'h3f)
         idle_r <= idle_r + 6'h01;
   end
   default clocking @(posedge clk);
   endclocking
   default disable iff (!resetn);
   reset_vals_a: assert property ($rose(resetn) |->
      read_bus_oe_n && !returned_strobe && write_ready)
      else $error("outputs off reset level");
   tri_idle_a: assert property (idle_r > 6'h30 |-> read_bus_oe_n)
      else $error("read bus driven without read");
   drive_cause_a: assert property ($fell(read_bus_oe_n) |->
      idle_r < 6'h28)
      else $error("read bus driven with no request");
   beat_hold_a: assert property (!read_bus_oe_n &&
      $changed(read_bus_out) |=> $stable(read_bus_out)[*3])
      else $error("beat too short");
   rs_rise_a: assert property (!returned_strobe |->
      ##[1:16] returned_strobe)
      else $error("returned strobe stuck low");
   rs_fall_a: assert property (returned_strobe |->
      ##[1:16] !returned_strobe)
      else $error("returned strobe stuck high");
   ret_pair_a: assert property ((c_in != c_n_in)[*8] |->
      returned_strobe != returned_strobe_n)
      else $error("returned pair not complementary");
   ret_follow_a: assert property ((c_in && !c_n_in)[*5] |->
      returned_strobe && !returned_strobe_n)
      else $error("returned strobe not following");
endmodule // dpsr_top_asserts
bind dpsr_top dpsr_top_asserts #(
   .DW(DW)
) dpsr_top_asserts_i (
   .clk(clk), .resetn(resetn), .c_in(c_in), .c_n_in(c_n_in),
   .read_port_sel_n(read_port_sel_n), .read_bus_out(read_bus_out),
   .read_bus_oe_n(read_bus_oe_n), .returned_strobe(returned_strobe),
   .returned_strobe_n(returned_strobe_n), .write_ready(write_ready)
);
`default_nettype wire

// ### verification/dpsr_ctl_model.sv
// controller model: both strobe pairs, half period 6 clk
// free-running from time zero; single parks the output pair high
`timescale 1ns/1ps
`default_nettype none
module dpsr_ctl_model (
   input wire logic clk,
   input wire logic single,
   output var logic [3:0] phase,
   output wire logic k,
   output wire logic k_n,
   output wire logic c,
   output wire logic c_n
);
   initial phase = 4'h0;
   always @(posedge clk)
      phase <= (phase == 4'hb) ? 4'h0 : phase + 4'h1;
   assign k = (phase < 4'h6);
   assign k_n = !k;
   assign c = single | k;
   assign c_n = single | k_n;
endmodule // dpsr_ctl_model
`default_nettype wire

// ### verification/tb_dpsr_top.sv
// testbench for dpsr_top, narrow variant
// strobes from dpsr_ctl_model, pins from here
`timescale 1ns/1ps
`default_nettype none
module tb_dpsr_top;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic single = 1'b0;
   logic [3:0] phase;
   wire k, k_n, c, c_n, oe_n, rs, rs_n, wr_rdy;
   wire [17:0] rd;
   logic [18:0] addr = 19'h00000;
   logic [17:0] wd = 18'h00000;
   logic [1:0] mask_n = 2'h3;
   logic rsel_n = 1'b1;
   logic wsel_n = 1'b1;
   int miscompares = 0;
   int n_checks = 0;
   int r;
   logic [18:0] ta [4] = '{19'h5, 19'h5, 19'h7ffff, 19'h5};
   logic [17:0] t0 [4] = '{18'h12345, 18'h0, 18'h0f0f0, 18'h3ffff};
   logic [17:0] t1 [4] = '{18'h2abcd, 18'h3ffff, 18'h30303, 18'h3ffff};
   logic [3:0] tm [4] = '{4'h0, 4'h6, 4'h0, 4'h0};
   logic tw [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
   logic [17:0] e0 [4] = '{18'h12345, 18'h12200, 18'h0f0f0, 18'h12200};
   logic [17:0] e1 [4] = '{18'h2abcd, 18'h3ffcd, 18'h30303, 18'h3ffcd};
   always #25 clk = ~clk;
   dpsr_ctl_model dpsr_ctl_model_i (.clk(clk), .single(single),
      .phase(phase), .k(k), .k_n(k_n), .c(c), .c_n(c_n));
   dpsr_top dpsr_top_i (.clk(clk), .resetn(resetn), .k_in(k),
      .k_n_in(k_n), .c_in(c), .c_n_in(c_n), .addr(addr),
      .write_bus_in(wd), .byte_lane_mask_n(mask_n),
      .read_port_sel_n(rsel_n), .write_port_sel_n(wsel_n),
      .read_bus_out(rd), .read_bus_oe_n(oe_n), .returned_strobe(rs),
      .returned_strobe_n(rs_n), .write_ready(wr_rdy));
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [17:0] got, input logic [17:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t: %h expected %h", $time, got, exp);
      end
   endtask
   task automatic to_ph(input logic [3:0] p);
      int i;
      for (i = 0; i < 40; i++)
      begin
         @(negedge clk);
         if (phase === p)
            return;
      end
      miscompares++;
      tally_and_finish();
   endtask
   task automatic cycle(input logic rn, input logic wn,
      input logic [18:0] ra, input logic [18:0] wa,
      input logic [17:0] d0, input logic [17:0] d1, input logic [3:0] m);
      to_ph(4'h8);
      @(posedge clk);
      rsel_n <= rn;
      wsel_n <= wn;
      addr <= ra;
      wd <= d0;
      mask_n <= m[1:0];
      to_ph(4'h2);
      @(posedge clk);
      rsel_n <= 1'b1;
      wsel_n <= 1'b1;
      addr <= wa;
      wd <= d1;
      mask_n <= m[3:2];
   endtask
   task automatic rd_chk(input logic [17:0] b0, input logic [17:0] b1);
      to_ph(4'h6);
      to_ph(4'h0);
      to_ph(4'h6);
      chk(rd, b0);
      chk({17'h0, oe_n}, 18'h0);
      to_ph(4'h0);
      chk(rd, b1);
      to_ph(4'h7);
      chk({17'h0, oe_n}, 18'h1);
   endtask
   initial
   begin
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      for (r = 0; r < 4; r++)
      begin
         cycle(1'b1, tw[r], 19'h0, ta[r], t0[r], t1[r], tm[r]);
         cycle(1'b0, 1'b1, ta[r], ta[r], 18'h0, 18'h0, 4'h0);
         rd_chk(e0[r], e1[r]);
      end
      to_ph(4'h0);
      @(posedge clk);
      single <= 1'b1;
      cycle(1'b0, 1'b1, 19'h7ffff, 19'h7ffff, 18'h0, 18'h0, 4'hf);
      rd_chk(18'h0f0f0, 18'h30303);
      to_ph(4'h5);
      chk({16'h0, rs, rs_n}, 18'h2);
      to_ph(4'hb);
      chk({16'h0, rs, rs_n}, 18'h1);
      @(posedge clk);
      resetn <= 1'b0;
      @(negedge clk);
      chk(rd, 18'h0);
      chk({15'h0, oe_n, rs_n, wr_rdy}, 18'h7);
      tally_and_finish();
   end
endmodule // tb_dpsr_top
`default_nettype wire
